// file: logic/snrel_host.sv
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module snrel_host #(
  parameter int unsigned SCLK_HALF = 4
) (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // Flash pins
  output snrel_pkg::snrel_pins_t spi_o,
  input wire logic [3:0] spi_io_i
);

  snrel_pkg::snrel_state_t state;
  snrel_pkg::snrel_phase_t phase;
  snrel_pkg::snrel_op_t op;
  snrel_pkg::snrel_op_t go_op;
  logic go_req;
  logic [15:0] arg0;
  logic [15:0] arg1;
  logic wp_mirror;
  logic [7:0] dat_byte;
  logic dat_last;
  logic dat_valid;
  logic cur_last;
  logic waiting;
  logic [6:0] idx;
  logic [6:0] rx_len;
  logic [7:0] gap_cnt;
  logic [7:0] tx_byte;
  logic tx_quad;
  logic eng_start;
  logic eng_busy;
  logic eng_done;
  logic eng_quad;
  logic [3:0] eng_cnt;
  logic [7:0] div_cnt;
  logic [7:0] sh_tx;
  logic [7:0] sh_rx;
  logic miso_m;
  logic miso_s;
  logic [7:0] dev_status;
  logic remap_full;
  logic refused;
  logic wen_sent;
  logic [15:0] ecc_page;
  logic [31:0] link_tbl [snrel_pkg::TABLE_LINKS];
  logic cs_n_q;
  logic sclk_q;
  logic [3:0] io_q;
  logic [3:0] oe_q;
  logic [7:0] cur_tx;
  logic [6:0] cur_hdr;
  logic [7:0] tbl_off;

  // Operation decoding
  function automatic logic fn_quad(input snrel_pkg::snrel_op_t o);
    return o[2] & o[1];
  endfunction : fn_quad

  function automatic logic fn_needs_wen(input snrel_pkg::snrel_op_t o);
    return o[2] || o == snrel_pkg::SNREL_OP_REMAP || o == snrel_pkg::SNREL_OP_ERASE;
  endfunction : fn_needs_wen

  function automatic logic [6:0] fn_hdr_len(input snrel_pkg::snrel_op_t o);
    unique case (o)
      snrel_pkg::SNREL_OP_REMAP: return 7'h05;
      snrel_pkg::SNREL_OP_TABLE, snrel_pkg::SNREL_OP_ECCPG: return 7'h02;
      snrel_pkg::SNREL_OP_ERASE: return 7'h04;
      default: return 7'h03;
    endcase
  endfunction : fn_hdr_len

  function automatic logic [7:0] fn_opcode(input snrel_pkg::snrel_op_t o);
    unique case (o)
      snrel_pkg::SNREL_OP_REMAP: return snrel_pkg::OPC_REMAP;
      snrel_pkg::SNREL_OP_TABLE: return snrel_pkg::OPC_TABLE;
      snrel_pkg::SNREL_OP_ECCPG: return snrel_pkg::OPC_ECCPG;
      snrel_pkg::SNREL_OP_ERASE: return snrel_pkg::OPC_ERASE;
      snrel_pkg::SNREL_OP_LOAD: return snrel_pkg::OPC_LOAD;
      snrel_pkg::SNREL_OP_RLOAD: return snrel_pkg::OPC_RLOAD;
      snrel_pkg::SNREL_OP_QLOAD: return snrel_pkg::OPC_QLOAD;
      default: return snrel_pkg::OPC_QRLOAD;
    endcase
  endfunction : fn_opcode

  // Header byte per operation and position
  function automatic logic [7:0] fn_tx(input snrel_pkg::snrel_op_t o, input logic [2:0] i,
                                       input logic [15:0] a0, input logic [15:0] a1);
    logic rm;
    logic er;
    rm = (o == snrel_pkg::SNREL_OP_REMAP);
    er = (o == snrel_pkg::SNREL_OP_ERASE);
    unique case (i)
      3'h0: return fn_opcode(o);
      3'h1: return rm ? a0[15:8] : (o[2] ? {4'h0, a0[11:8]} : snrel_pkg::DUMMY);
      3'h2: return er ? a0[15:8] : a0[7:0];
      3'h3: return rm ? a1[15:8] : a0[7:0];
      default: return a1[7:0];
    endcase
  endfunction : fn_tx

  // Current header byte and length
  always_comb begin
    unique case (phase)
      snrel_pkg::SNREL_PH_WEN: begin
        cur_hdr = 7'h01;
        cur_tx = snrel_pkg::OPC_WREN;
      end
      snrel_pkg::SNREL_PH_POLL: begin
        cur_hdr = 7'h02;
        cur_tx = (idx == 7'h00) ? snrel_pkg::OPC_RDSR : snrel_pkg::SR_ADDR;
      end
      default: begin
        cur_hdr = fn_hdr_len(op);
        cur_tx = fn_tx(op, idx[2:0], arg0, arg1);
      end
    endcase
  end

  assign spi_o = '{cs_n: cs_n_q, sclk: sclk_q, io: io_q, oe: oe_q};
  assign tbl_off = reg_addr_i - snrel_pkg::RA_TABLE;

  // Data-out line synchroniser
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end else if (ce_i) begin
      miso_m <= spi_io_i[1];
      miso_s <= miso_m;
    end
  end

  // Software command and argument registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      go_req <= 1'b0;
      go_op <= snrel_pkg::SNREL_OP_REMAP;
      arg0 <= 16'h0000;
      arg1 <= 16'h0000;
      wp_mirror <= 1'b0;
    end else if (ce_i) begin
      go_req <= reg_we_i && reg_addr_i == snrel_pkg::RA_CTRL
                && reg_wdata_i[snrel_pkg::CTRL_GO];
      if (reg_we_i && reg_addr_i == snrel_pkg::RA_CTRL) begin
        go_op <= snrel_pkg::snrel_op_t'(reg_wdata_i[2:0]);
      end
      if (reg_we_i && reg_addr_i == snrel_pkg::RA_ARG0) begin
        arg0 <= reg_wdata_i[15:0];
      end
      if (reg_we_i && reg_addr_i == snrel_pkg::RA_ARG1) begin
        arg1 <= reg_wdata_i[15:0];
      end
      if (reg_we_i && reg_addr_i == snrel_pkg::RA_CFG) begin
        wp_mirror <= reg_wdata_i[snrel_pkg::CFG_WPE];
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_re_i) begin
        if (reg_addr_i == snrel_pkg::RA_STAT) begin
          reg_rdata_o <= {20'h00000, remap_full, refused, dat_valid,
                          state != snrel_pkg::SNREL_IDLE, dev_status};
        end else if (reg_addr_i == snrel_pkg::RA_ECCPG) begin
          reg_rdata_o <= {16'h0000, ecc_page};
        end else if (reg_addr_i == snrel_pkg::RA_ARG0) begin
          reg_rdata_o <= {16'h0000, arg0};
        end else if (reg_addr_i == snrel_pkg::RA_ARG1) begin
          reg_rdata_o <= {16'h0000, arg1};
        end else if (reg_addr_i == snrel_pkg::RA_CFG) begin
          reg_rdata_o <= {31'h0000_0000, wp_mirror};
        end else if (tbl_off < 8'(snrel_pkg::TABLE_LINKS)) begin
          reg_rdata_o <= link_tbl[tbl_off[4:0]];
        end
      end
    end
  end

  // Bit engine: mode 0 clock, shifts on falling edge, samples before it
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eng_busy <= 1'b0;
      eng_done <= 1'b0;
      eng_quad <= 1'b0;
      eng_cnt <= 4'h0;
      div_cnt <= 8'h00;
      sclk_q <= 1'b0;
      sh_tx <= 8'h00;
      sh_rx <= 8'h00;
      io_q <= 4'hC;
      oe_q <= 4'hD;
    end else if (ce_i) begin
      eng_done <= 1'b0;
      if (eng_start) begin
        eng_busy <= 1'b1;
        eng_quad <= tx_quad;
        div_cnt <= 8'h00;
        sclk_q <= 1'b0;
        eng_cnt <= tx_quad ? snrel_pkg::ENG_QCLK : snrel_pkg::ENG_SCLK;
        sh_tx <= tx_quad ? {tx_byte[3:0], 4'h0} : {tx_byte[6:0], 1'b0};
        io_q <= tx_quad ? tx_byte[7:4] : {3'b110, tx_byte[7]};
        oe_q <= tx_quad ? 4'hF : 4'hD;
      end else if (eng_busy) begin
        if (div_cnt == 8'(SCLK_HALF - 1)) begin
          div_cnt <= 8'h00;
          sclk_q <= !sclk_q;
          if (sclk_q) begin
            sh_rx <= {sh_rx[6:0], miso_s};
            if (eng_cnt == 4'h1) begin
              eng_busy <= 1'b0;
              eng_done <= 1'b1;
              io_q <= 4'hC;
              oe_q <= 4'hD;
            end else begin
              eng_cnt <= eng_cnt - 4'h1;
              io_q <= eng_quad ? sh_tx[7:4] : {3'b110, sh_tx[7]};
              sh_tx <= eng_quad ? {sh_tx[3:0], 4'h0} : {sh_tx[6:0], 1'b0};
            end
          end
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end

  // Command sequencer
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= snrel_pkg::SNREL_IDLE;
      phase <= snrel_pkg::SNREL_PH_WEN;
      op <= snrel_pkg::SNREL_OP_REMAP;
      idx <= 7'h00;
      rx_len <= 7'h00;
      waiting <= 1'b0;
      eng_start <= 1'b0;
      tx_byte <= 8'h00;
      tx_quad <= 1'b0;
      cs_n_q <= 1'b1;
      gap_cnt <= 8'h00;
      dat_byte <= 8'h00;
      dat_last <= 1'b0;
      dat_valid <= 1'b0;
      cur_last <= 1'b0;
      dev_status <= 8'h00;
      remap_full <= 1'b0;
      refused <= 1'b0;
      wen_sent <= 1'b0;
      ecc_page <= 16'h0000;
      for (int i = 0; i < snrel_pkg::TABLE_LINKS; i++) begin
        link_tbl[i] <= 32'h0000_0000;
      end
    end else if (ce_i) begin
      eng_start <= 1'b0;
      if (reg_we_i && reg_addr_i == snrel_pkg::RA_DATA && !dat_valid) begin
        dat_byte <= reg_wdata_i[7:0];
        dat_last <= reg_wdata_i[snrel_pkg::DATA_LAST];
        dat_valid <= 1'b1;
      end
      unique case (state)
        snrel_pkg::SNREL_IDLE: begin
          wen_sent <= 1'b0;
          if (go_req) begin
            op <= go_op;
            refused <= 1'b0;
            if ((go_op == snrel_pkg::SNREL_OP_REMAP && remap_full)
                || (fn_quad(go_op) && wp_mirror)) begin
              refused <= 1'b1;
            end else begin
              phase <= fn_needs_wen(go_op) ? snrel_pkg::SNREL_PH_WEN
                                           : snrel_pkg::SNREL_PH_MAIN;
              idx <= 7'h00;
              waiting <= 1'b0;
              cs_n_q <= 1'b0;
              state <= snrel_pkg::SNREL_TX;
            end
          end
        end
        snrel_pkg::SNREL_TX: begin
          if (!waiting) begin
            tx_byte <= cur_tx;
            tx_quad <= 1'b0;
            eng_start <= 1'b1;
            waiting <= 1'b1;
          end else if (eng_done) begin
            waiting <= 1'b0;
            if (idx == cur_hdr - 7'h01) begin
              idx <= 7'h00;
              if (phase == snrel_pkg::SNREL_PH_POLL) begin
                rx_len <= 7'h01;
                state <= snrel_pkg::SNREL_RX;
              end else if (phase == snrel_pkg::SNREL_PH_MAIN
                           && op == snrel_pkg::SNREL_OP_TABLE) begin
                rx_len <= snrel_pkg::TABLE_BYTES;
                state <= snrel_pkg::SNREL_RX;
              end else if (phase == snrel_pkg::SNREL_PH_MAIN
                           && op == snrel_pkg::SNREL_OP_ECCPG) begin
                rx_len <= snrel_pkg::ECC_BYTES;
                state <= snrel_pkg::SNREL_RX;
              end else if (phase == snrel_pkg::SNREL_PH_MAIN && op[2]) begin
                state <= snrel_pkg::SNREL_DATA;
              end else begin
                cs_n_q <= 1'b1;
                gap_cnt <= 8'h00;
                state <= snrel_pkg::SNREL_GAP;
              end
            end else begin
              idx <= idx + 7'h01;
            end
          end
        end
        snrel_pkg::SNREL_RX: begin
          if (!waiting) begin
            tx_byte <= snrel_pkg::DUMMY;
            tx_quad <= 1'b0;
            eng_start <= 1'b1;
            waiting <= 1'b1;
          end else if (eng_done) begin
            waiting <= 1'b0;
            if (phase == snrel_pkg::SNREL_PH_POLL) begin
              dev_status <= sh_rx;
            end else if (op == snrel_pkg::SNREL_OP_TABLE) begin
              link_tbl[idx[6:2]] <= {link_tbl[idx[6:2]][23:0], sh_rx};
            end else begin
              ecc_page <= {ecc_page[7:0], sh_rx};
            end
            if (idx == rx_len - 7'h01) begin
              cs_n_q <= 1'b1;
              gap_cnt <= 8'h00;
              state <= snrel_pkg::SNREL_GAP;
            end else begin
              idx <= idx + 7'h01;
            end
          end
        end
        snrel_pkg::SNREL_DATA: begin
          if (!waiting) begin
            if (dat_valid) begin
              tx_byte <= dat_byte;
              tx_quad <= fn_quad(op);
              cur_last <= dat_last;
              dat_valid <= 1'b0;
              eng_start <= 1'b1;
              waiting <= 1'b1;
            end
          end else if (eng_done) begin
            waiting <= 1'b0;
            if (cur_last) begin
              cs_n_q <= 1'b1;
              gap_cnt <= 8'h00;
              state <= snrel_pkg::SNREL_GAP;
            end
          end
        end
        snrel_pkg::SNREL_GAP: begin
          if (gap_cnt == 8'(snrel_pkg::CS_GAP_CYC - 1)) begin
            idx <= 7'h00;
            if (phase == snrel_pkg::SNREL_PH_WEN) begin
              wen_sent <= 1'b1;
              phase <= snrel_pkg::SNREL_PH_MAIN;
              cs_n_q <= 1'b0;
              state <= snrel_pkg::SNREL_TX;
            end else if (phase == snrel_pkg::SNREL_PH_MAIN
                         && (op == snrel_pkg::SNREL_OP_REMAP
                             || op == snrel_pkg::SNREL_OP_ERASE)) begin
              phase <= snrel_pkg::SNREL_PH_POLL;
              cs_n_q <= 1'b0;
              state <= snrel_pkg::SNREL_TX;
            end else if (phase == snrel_pkg::SNREL_PH_POLL
                         && dev_status[snrel_pkg::SR_BUSY]) begin
              cs_n_q <= 1'b0;
              state <= snrel_pkg::SNREL_TX;
            end else begin
              if (phase == snrel_pkg::SNREL_PH_POLL) begin
                remap_full <= dev_status[snrel_pkg::SR_FULL];
              end
              state <= snrel_pkg::SNREL_IDLE;
            end
          end else begin
            gap_cnt <= gap_cnt + 8'h01;
          end
        end
        default: state <= snrel_pkg::SNREL_IDLE;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  logic main_hdr;
  assign main_hdr = eng_start && state == snrel_pkg::SNREL_TX
                    && phase == snrel_pkg::SNREL_PH_MAIN;

  AST_REMAP_OPC: assert property (
    main_hdr && idx == 7'h00 && op == snrel_pkg::SNREL_OP_REMAP |-> tx_byte == 8'hA1)
    else $error("remap opcode wrong");
  AST_TABLE_OPC: assert property (
    main_hdr && idx == 7'h00 && op == snrel_pkg::SNREL_OP_TABLE |-> tx_byte == 8'hA5)
    else $error("table opcode wrong");
  AST_ECC_OPC: assert property (
    main_hdr && idx == 7'h00 && op == snrel_pkg::SNREL_OP_ECCPG |-> tx_byte == 8'hA9)
    else $error("ecc page opcode wrong");
  AST_ERASE_DUMMY: assert property (
    main_hdr && idx == 7'h01 && op == snrel_pkg::SNREL_OP_ERASE |-> tx_byte == 8'h00)
    else $error("erase dummy byte wrong");
  AST_WEN_FIRST: assert property (
    main_hdr && idx == 7'h00 && fn_needs_wen(op) |-> wen_sent)
    else $error("write enable not sent first");
  AST_COL_MASK: assert property (
    main_hdr && idx == 7'h01 && op[2] |-> tx_byte[7:4] == 4'h0)
    else $error("column upper bits not zero");
  AST_QUAD_DATA: assert property (
    eng_start && state == snrel_pkg::SNREL_DATA |-> tx_quad == fn_quad(op))
    else $error("data width wrong");
  AST_CS_BOUNDARY: assert property (
    $rose(cs_n_q) |-> !eng_busy && !sclk_q)
    else $error("chip select rose mid byte");
  AST_CS_HELD: assert property (
    state == snrel_pkg::SNREL_DATA |-> !cs_n_q)
    else $error("chip select high in load");
  AST_QUAD_REFUSE: assert property (
    ce_i && state == snrel_pkg::SNREL_IDLE && go_req && fn_quad(go_op) && wp_mirror
    |=> refused && state == snrel_pkg::SNREL_IDLE)
    else $error("quad not refused");

  COV_LOAD_END: cover property (state == snrel_pkg::SNREL_DATA && eng_done && cur_last);
  COV_POLL_DONE: cover property (
    state == snrel_pkg::SNREL_GAP && phase == snrel_pkg::SNREL_PH_POLL
    ##1 state == snrel_pkg::SNREL_IDLE);
  COV_TABLE_RX: cover property (
    state == snrel_pkg::SNREL_RX && op == snrel_pkg::SNREL_OP_TABLE && idx == 7'h4F);

endmodule : snrel_host

// file: logic/snrel_pkg.sv
package snrel_pkg;
  // Timing
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned CS_HIGH_NS = 50;
  localparam int unsigned CS_GAP_RAW = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CS_GAP_CYC = (CS_GAP_RAW < 1) ? 1 : CS_GAP_RAW;
  localparam logic [3:0] ENG_SCLK = 4'h8;
  localparam logic [3:0] ENG_QCLK = 4'h2;
  // Flash opcodes
  localparam logic [7:0] OPC_WREN = 8'h06;
  localparam logic [7:0] OPC_REMAP = 8'hA1;
  localparam logic [7:0] OPC_TABLE = 8'hA5;
  localparam logic [7:0] OPC_ECCPG = 8'hA9;
  localparam logic [7:0] OPC_ERASE = 8'hD8;
  localparam logic [7:0] OPC_LOAD = 8'h02;
  localparam logic [7:0] OPC_RLOAD = 8'h84;
  localparam logic [7:0] OPC_QLOAD = 8'h32;
  localparam logic [7:0] OPC_QRLOAD = 8'h34;
  localparam logic [7:0] OPC_RDSR = 8'h0F;
  localparam logic [7:0] SR_ADDR = 8'hC0;
  localparam logic [7:0] DUMMY = 8'h00;
  // Device status bit positions
  localparam int unsigned SR_BUSY = 0;
  localparam int unsigned SR_FULL = 6;
  // Readback sizes
  localparam int unsigned TABLE_LINKS = 20;
  localparam logic [6:0] TABLE_BYTES = 7'h50;
  localparam logic [6:0] ECC_BYTES = 7'h02;
  // Register map, field positions
  localparam logic [7:0] RA_CTRL = 8'h00;
  localparam logic [7:0] RA_ARG0 = 8'h01;
  localparam logic [7:0] RA_ARG1 = 8'h02;
  localparam logic [7:0] RA_DATA = 8'h03;
  localparam logic [7:0] RA_STAT = 8'h04;
  localparam logic [7:0] RA_ECCPG = 8'h05;
  localparam logic [7:0] RA_CFG = 8'h06;
  localparam logic [7:0] RA_TABLE = 8'h10;
  localparam int unsigned CTRL_GO = 3;
  localparam int unsigned DATA_LAST = 8;
  localparam int unsigned CFG_WPE = 0;
  localparam int unsigned ST_BUSY = 8;
  localparam int unsigned ST_DPEND = 9;
  localparam int unsigned ST_REFUSED = 10;
  localparam int unsigned ST_FULL = 11;
  // Operations
  typedef enum logic [2:0] {
    SNREL_OP_REMAP = 3'h0, SNREL_OP_TABLE = 3'h1, SNREL_OP_ECCPG = 3'h2,
    SNREL_OP_ERASE = 3'h3, SNREL_OP_LOAD = 3'h4, SNREL_OP_RLOAD = 3'h5,
    SNREL_OP_QLOAD = 3'h6, SNREL_OP_QRLOAD = 3'h7
  } snrel_op_t;
  typedef enum logic [4:0] {
    SNREL_IDLE = 5'h01, SNREL_TX = 5'h02, SNREL_RX = 5'h04,
    SNREL_DATA = 5'h08, SNREL_GAP = 5'h10
  } snrel_state_t;
  typedef enum logic [1:0] {
    SNREL_PH_WEN = 2'h0, SNREL_PH_MAIN = 2'h1, SNREL_PH_POLL = 2'h2
  } snrel_phase_t;
  // Pin bundle: io0 data in, io1 data out, io2 write protect, io3 hold
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
    logic [3:0] oe;
  } snrel_pins_t;
endpackage : snrel_pkg

// file: test/snrel_flash_model.sv
`timescale 1ns/1ps
module snrel_flash_model #(
  parameter logic [15:0] FAIL_PAGE = 16'h0ABC,
  parameter int BUSY_POLLS = 2,
  // First page of the protected range; erases at or above it are skipped
  parameter logic [15:0] PROT_PAGE = 16'hFFC0
) (
  // Host pins
  input wire snrel_pkg::snrel_pins_t pins_i,
  // Flash data out
  output logic do_o
);
  logic [7:0] rx [0:7];
  logic [7:0] sh;
  logic [7:0] ob;
  logic [7:0] buf_mem [0:2111];
  logic [31:0] remap_table [0:19];
  logic [15:0] erased;
  logic [4:0] used;
  logic write_enable_latch;
  int bits, nb, busy, col, frames;
  // Byte streamed back for status, table and failure-page reads
  function automatic logic [7:0] out_byte(input int i);
    case (rx[0])
      8'hA5: out_byte = (i < 80) ? remap_table[i / 4][31 - 8 * (i % 4) -: 8]
                                 : 8'h00;
      8'hA9: out_byte = (i == 0) ? FAIL_PAGE[15:8] : FAIL_PAGE[7:0];
      default: out_byte = {1'b0, used == 5'h14, 4'h0,
                           write_enable_latch, busy != 0};
    endcase
  endfunction : out_byte
  // Power-up state: empty table, erased buffer
  initial begin
    do_o = 1'b0;
    write_enable_latch = 1'b0;
    used = 5'h00;
    busy = 0;
    frames = 0;
    erased = 16'hFFFF;
    foreach (remap_table[i]) remap_table[i] = 32'h00000000;
    foreach (buf_mem[i]) buf_mem[i] = 8'hFF;
  end
  // A new frame restarts the byte counter
  always @(negedge pins_i.cs_n) begin
    nb = 0;
    bits = 0;
    frames++;
  end
  // Shift in on the rising edge, a nibble per edge for quad data
  always @(posedge pins_i.sclk) if (!pins_i.cs_n) begin
    if (nb > 2 && rx[0] inside {8'h32, 8'h34}) begin
      sh = {sh[3:0], pins_i.io};
      bits += 4;
    end else begin
      sh = {sh[6:0], pins_i.io[0]};
      bits++;
    end
    if (bits == 8) begin
      if (nb < 8) rx[nb] = sh;
      col = {rx[1][3:0], rx[2]};
      if (write_enable_latch && nb == 2 && rx[0] inside {8'h02, 8'h32}) begin
        foreach (buf_mem[i]) buf_mem[i] = 8'hFF;
      end
      // Correction is off here, so the extra area keeps the loaded bytes
      if (write_enable_latch && nb > 2 && rx[0] inside {8'h02, 8'h84, 8'h32, 8'h34}
          && col + nb < 2115)
        buf_mem[col + nb - 3] = sh;
      nb++;
      bits = 0;
    end
  end
  // Drive read data on the falling edge, otherwise keep the line moving
  always @(negedge pins_i.sclk) if (!pins_i.cs_n) begin
    ob = out_byte(nb - 2);
    if (nb >= 2 && rx[0] inside {8'h0F, 8'hA5, 8'hA9}) do_o = ob[7 - bits];
    else do_o = ~do_o;
  end
  // Commands take effect when chip select rises on a byte boundary; the status read counts busy down without the boundary check
  always @(posedge pins_i.cs_n) begin
    do_o = ~do_o;
    if (bits == 0 && nb == 1 && rx[0] == 8'h06) write_enable_latch = 1'b1;
    if (bits == 0 && nb == 5 && rx[0] == 8'hA1
        && write_enable_latch) begin
      // Enabled-valid link; array accesses to the logical block follow it
      if (used < 5'h14) begin
        remap_table[used] = {2'b10, rx[1][5:0], rx[2], rx[3], rx[4]};
        used++;
      end
      busy = BUSY_POLLS;
    end
    if (bits == 0 && nb == 4 && rx[0] == 8'hD8 && write_enable_latch) begin
      if ({rx[2], rx[3]} < PROT_PAGE) erased = {rx[2], rx[3]};
      busy = BUSY_POLLS;
    end
    if (nb == 3 && rx[0] == 8'h0F && busy > 0) begin
      busy--;
      if (busy == 0) write_enable_latch = 1'b0;
    end
  end
endmodule : snrel_flash_model

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i;
  logic rstn_i;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic we;
  logic ce;
  logic re;
  logic [31:0] rdata;
  logic [31:0] r;
  logic do_line;
  snrel_pkg::snrel_pins_t spi;
  int error_cnt = 0;
  int checked = 0;
  int n;
  snrel_host #(.SCLK_HALF(4)) i_snrel_host (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .spi_o(spi),
    .spi_io_i({spi.io[3:2], spi.oe[1] ? spi.io[1] : do_line, spi.io[0]}));
  snrel_flash_model i_snrel_flash_model (.pins_i(spi), .do_o(do_line));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge sys_clk_i);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge sys_clk_i);
    re <= 1'b0;
    // Read data stand for this one cycle; take them mid-cycle
    @(negedge sys_clk_i);
    r = rdata;
  endtask : rd
  task automatic cmd(input logic [2:0] o, input logic [15:0] a0, input logic [15:0] a1);
    wr(snrel_pkg::RA_ARG0, {16'h0000, a0});
    wr(snrel_pkg::RA_ARG1, {16'h0000, a1});
    wr(snrel_pkg::RA_CTRL, {28'h0000000, 1'b1, o});
    repeat (4) @(posedge sys_clk_i);
  endtask : cmd
  // Poll status until the sequencer is back to idle
  task automatic idle;
    r = 32'h00000100;
    n = 0;
    while (r[snrel_pkg::ST_BUSY] !== 1'b0 && n < 5000) begin
      rd(snrel_pkg::RA_STAT);
      n++;
    end
    chk({31'h0, n < 5000}, 32'h1);
  endtask : idle
  // Load command, each byte handed over once the previous one is taken
  task automatic load(input logic [2:0] o, input logic [15:0] c, input logic [7:0] q [$]);
    cmd(o, c, 16'h0000);
    foreach (q[i]) begin
      r = 32'h00000200;
      for (int k = 0; k < 500 && r[snrel_pkg::ST_DPEND] !== 1'b0; k++) rd(snrel_pkg::RA_STAT);
      wr(snrel_pkg::RA_DATA, {23'h0, i == q.size() - 1, q[i]});
    end
    idle();
  endtask : load
  function automatic logic [31:0] bw();
    bw = {i_snrel_flash_model.buf_mem[0], i_snrel_flash_model.buf_mem[5],
      i_snrel_flash_model.buf_mem[6], i_snrel_flash_model.buf_mem[7]};
  endfunction : bw
  task automatic t_reset;
    chk({23'h0, spi.cs_n, spi.io, spi.oe}, {23'h0, 1'b1, 8'hCD});
    rd(snrel_pkg::RA_STAT);
    chk(r, 32'h0);
    rd(8'h30);
    chk(r, 32'h0);
    // A write while the clock enable is low must leave no trace
    ce <= 1'b0;
    wr(snrel_pkg::RA_ARG0, 32'h0000_1234);
    ce <= 1'b1;
    rd(snrel_pkg::RA_ARG0);
    chk(r, 32'h0);
  endtask : t_reset
  task automatic t_remap;
    cmd(3'h0, 16'h0123, 16'h0456);
    idle();
    chk(i_snrel_flash_model.remap_table[0], 32'h81230456);
    chk({31'h0, i_snrel_flash_model.write_enable_latch}, 32'h0);
    cmd(3'h1, 16'h0, 16'h0);
    idle();
    rd(snrel_pkg::RA_TABLE);
    chk(r, 32'h81230456);
    rd(snrel_pkg::RA_TABLE + 8'h01);
    chk(r, 32'h0);
  endtask : t_remap
  task automatic t_full;
    for (int i = 1; i < 20; i++) begin
      cmd(3'h0, 16'h0200 + i[15:0], 16'h0300 + i[15:0]);
      idle();
    end
    rd(snrel_pkg::RA_STAT);
    chk({31'h0, r[snrel_pkg::ST_FULL]}, 32'h1);
    cmd(3'h0, 16'h0001, 16'h0002);
    rd(snrel_pkg::RA_STAT);
    chk({31'h0, r[snrel_pkg::ST_REFUSED]}, 32'h1);
    chk({27'h0, i_snrel_flash_model.used}, 32'h14);
    cmd(3'h1, 16'h0, 16'h0);
    idle();
    rd(snrel_pkg::RA_TABLE + 8'h13);
    chk(r, 32'h82130313);
  endtask : t_full
  task automatic t_misc;
    cmd(3'h2, 16'h0, 16'h0);
    idle();
    rd(snrel_pkg::RA_ECCPG);
    chk(r, 32'h00000ABC);
    cmd(3'h3, 16'h0140, 16'h0);
    idle();
    chk({16'h0, i_snrel_flash_model.erased}, 32'h00000140);
    chk({31'h0, i_snrel_flash_model.write_enable_latch}, 32'h0);
    load(3'h4, 16'hF005, '{8'hA5, 8'h5A});
    chk(bw(), 32'hFFA55AFF);
    load(3'h5, 16'h0000, '{8'h3C});
    chk(bw(), 32'h3CA55AFF);
    load(3'h6, 16'h0007, '{8'hC3});
    chk(bw(), 32'hFFFFFFC3);
    load(3'h7, 16'h0006, '{8'h96});
    chk(bw(), 32'hFFFF96C3);
    wr(snrel_pkg::RA_CFG, 32'h1);
    n = i_snrel_flash_model.frames;
    cmd(3'h6, 16'h0, 16'h0);
    rd(snrel_pkg::RA_STAT);
    chk({31'h0, r[snrel_pkg::ST_REFUSED]}, 32'h1);
    chk(i_snrel_flash_model.frames - n, 32'h0);
    load(3'h4, 16'h0000, '{8'h11});
    chk(bw(), 32'h11FFFFFF);
  endtask : t_misc
  task automatic test_done;
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // Main sequence
  initial begin
    rstn_i = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    we = 1'b0;
    re = 1'b0;
    ce = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_remap();
    t_full();
    t_misc();
    test_done();
  end
  // Watchdog
  initial begin
    #10000000;
    error_cnt++;
    test_done();
  end
endmodule : tb_top
